// ===== cmpc_pkg.sv
// Purpose: shared constants and types for the comparator control block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: printed offsets are not word multiples, so byte address = 4 * index
package cmpc_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_MUX = 4'h2;
   localparam logic [3:0] IDX_THRESH = 4'h4;
   localparam logic [3:0] IDX_IRQEN = 4'h6;
   localparam logic [3:0] IDX_STATUS = 4'h7;
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MUX = 8'h00;
   localparam logic [7:0] RST_THRESH = 8'hff;
   localparam logic [7:0] RST_IRQEN = 8'h00;
   // field positions
   localparam int CTRL_STBY_BIT = 7;
   localparam int CTRL_PAD_BIT = 6;
   localparam int CTRL_EDGE_LSB = 4;
   localparam int CTRL_LP_BIT = 3;
   localparam int CTRL_HYS_LSB = 1;
   localparam int CTRL_EN_BIT = 0;
   localparam int MUX_INV_BIT = 7;
   localparam int MUX_POS_LSB = 3;
   localparam int MUX_NEG_LSB = 0;
   localparam int STAT_STATE_BIT = 4;
   localparam int STAT_FLAG_BIT = 0;
   // writable masks
   localparam logic [7:0] MUX_WMASK = 8'h9b;
   localparam logic [7:0] IRQEN_WMASK = 8'h01;
   // edge select encodings
   localparam logic [1:0] EDGE_ANY = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_RISE = 2'h3;
   // negative select value for the internal threshold reference
   localparam logic [1:0] NEG_THRESH = 2'h3;
   // synchroniser depth of the status state bit
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic standby_run;
      logic pad_output_enable;
      logic [1:0] edge_select;
      logic low_power;
      logic [1:0] hysteresis_level;
      logic enable;
   } cmpc_ctrl_t;

   // controls driven out to the analog core
   typedef struct packed {
      logic enable;
      logic low_power;
      logic [1:0] hysteresis_level;
      logic [1:0] pos_input_select;
      logic [1:0] neg_input_select;
      logic use_threshold;
      logic [7:0] threshold_level;
   } cmpc_analog_t;
endpackage : cmpc_pkg

// ===== cmpc_regs.sv
// Purpose: register bank and digital control around an analog comparator
// Assumes: apb slave on pclk, zero wait states; analog output is asynchronous
// Notes: the analog core itself sits outside this module
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module cmpc_regs
   import cmpc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system power state
   input wire logic standby_sleep,
   // analog core
   input wire logic raw_compare,
   output cmpc_analog_t analog_ctrl,
   // pad and event
   output logic pad_out,
   output logic pad_oe,
   output logic compare_event,
   // interrupt
   output logic compare_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic [7:0] ctrl_q;
   logic [7:0] mux_q;
   logic [7:0] thresh_q;
   logic [7:0] irqen_q;
   logic flag;
   logic [SYNC_STAGES-2:0] raw_sync;
   logic synced;
   logic state_prev;
   cmpc_ctrl_t ctrl;

   // misaligned or out-of-range addresses match nothing and so read zero
   function automatic logic reg_hit(input logic [11:0] addr, input logic [3:0] index);
      return (addr[1:0] == 2'b00) && (addr[11:6] == 6'h00) && (addr[5:2] == index);
   endfunction : reg_hit

   wire access = psel && penable;
   wire wr = access && pwrite && pstrb[0];
   wire hit_ctrl = reg_hit(paddr, IDX_CTRL);
   wire hit_mux = reg_hit(paddr, IDX_MUX);
   wire hit_thresh = reg_hit(paddr, IDX_THRESH);
   wire hit_irqen = reg_hit(paddr, IDX_IRQEN);
   wire hit_status = reg_hit(paddr, IDX_STATUS);

   assign ctrl = cmpc_ctrl_t'(ctrl_q);

   ////////////////////////////////////////////////////////////////////////////
   // comparator running condition and output path

   // without standby-run the comparator stops while the system sleeps
   wire running = ctrl.enable && !(standby_sleep && !ctrl.standby_run);
   // the analog output is asynchronous: two flops stand before any logic reads it
   wire raw_level = raw_sync[SYNC_STAGES-2];
   // raw polarity comes from the analog core; invert applies to all consumers
   wire out_level = running && (raw_level ^ mux_q[MUX_INV_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   // synchroniser and edge detection

   // peripheral clock is gated in standby, so edge detection freezes there; the status state bit still follows
   wire clk_live = !standby_sleep;
   wire next_state_prev = clk_live ? synced : state_prev;
   wire rise = clk_live && synced && !state_prev;
   wire fall = clk_live && !synced && state_prev;
   wire edge_hit = (ctrl.edge_select == EDGE_ANY) ? (rise || fall) :
                   (ctrl.edge_select == EDGE_FALL) ? fall :
                   (ctrl.edge_select == EDGE_RISE) ? rise : 1'b0;
   wire flag_clr = wr && hit_status && pwdata[STAT_FLAG_BIT];
   // an edge in the clearing cycle wins so no event is lost
   wire next_flag = edge_hit ? 1'b1 : (flag_clr ? 1'b0 : flag);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_sync <= '0;
         synced <= 1'b0;
         state_prev <= 1'b0;
         flag <= 1'b0;
      end else begin
         // first stage read only by the second; the state flop is the third cycle
         raw_sync <= {raw_sync[SYNC_STAGES-3:0], raw_compare};
         synced <= out_level;
         state_prev <= next_state_prev;
         flag <= next_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= RST_CTRL;
         mux_q <= RST_MUX;
         thresh_q <= RST_THRESH;
         irqen_q <= RST_IRQEN;
      end else begin
         if (wr && hit_ctrl) begin
            ctrl_q <= pwdata[7:0];
         end
         if (wr && hit_mux) begin
            mux_q <= pwdata[7:0] & MUX_WMASK;
         end
         if (wr && hit_thresh) begin
            thresh_q <= pwdata[7:0];
         end
         if (wr && hit_irqen) begin
            irqen_q <= pwdata[7:0] & IRQEN_WMASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux and outputs

   wire [7:0] status_val = {3'b000, synced, 3'b000, flag};
   wire [7:0] rd_val = hit_ctrl ? ctrl_q :
                       hit_mux ? mux_q :
                       hit_thresh ? thresh_q :
                       hit_irqen ? irqen_q :
                       hit_status ? status_val : 8'h00;
   wire [31:0] next_prdata = (psel && !penable && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;

   cmpc_analog_t next_analog;
   assign next_analog.enable = running;
   assign next_analog.low_power = ctrl.low_power;
   assign next_analog.hysteresis_level = ctrl.hysteresis_level;
   assign next_analog.pos_input_select = mux_q[MUX_POS_LSB +: 2];
   assign next_analog.neg_input_select = mux_q[MUX_NEG_LSB +: 2];
   assign next_analog.use_threshold = (mux_q[MUX_NEG_LSB +: 2] == NEG_THRESH);
   assign next_analog.threshold_level = thresh_q;

   // one pclk of latency on the pad and event: the output must come from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         analog_ctrl <= '0;
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         compare_event <= 1'b0;
         compare_irq <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= psel && !penable;
         pslverr <= 1'b0;
         analog_ctrl <= next_analog;
         pad_out <= out_level;
         pad_oe <= ctrl.pad_output_enable && running;
         compare_event <= out_level;
         compare_irq <= next_flag && irqen_q[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   a_reset_values: assert property (@(posedge pclk)
      $rose(presetn) |-> ctrl_q == RST_CTRL && thresh_q == RST_THRESH)
      else $error("reset values wrong");

   a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      compare_irq == $past((edge_hit || flag && !flag_clr) && irqen_q[0]))
      else $error("irq does not follow flag and enable");

   a_clear_one: assert property (@(posedge pclk) disable iff (!presetn)
      flag_clr && !edge_hit |=> !flag)
      else $error("flag not cleared by write one");

   a_write_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      flag && !flag_clr |=> flag)
      else $error("flag lost without clear");

   a_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl.edge_select == EDGE_RISE && fall && !flag && !flag_clr |=> !flag)
      else $error("falling edge set flag in rise mode");

   a_reserved_edge: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl.edge_select == 2'h1 && !flag |=> !flag)
      else $error("reserved edge mode set flag");

   a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> synced == $past(out_level))
      else $error("state not one cycle behind the output level");

   a_standby_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      standby_sleep && !flag_clr |=> flag == $past(flag))
      else $error("flag changed in standby");

   a_pad_enable: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl.pad_output_enable |=> !pad_oe)
      else $error("pad driven while disabled");

   a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
      mux_q[6:5] == 2'b00 && mux_q[2] == 1'b0 && irqen_q[7:1] == 7'h00)
      else $error("unused bits not zero");

   a_raw_sync: assert property (@(posedge pclk) disable iff (!presetn)
      raw_level == $past(raw_compare, 2))
      else $error("raw output not two flops behind");

   a_pready_setup: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("no ready in access cycle");

   a_pready_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && !penable) |=> !pready)
      else $error("ready outside access cycle");

   a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside a read");

   a_write_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_ctrl |=> ctrl_q == $past(pwdata[7:0]))
      else $error("control write lost");

   a_write_mux: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_mux |=> mux_q == ($past(pwdata[7:0]) & MUX_WMASK))
      else $error("input select write lost");

   a_write_thresh: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_thresh |=> thresh_q == $past(pwdata[7:0]))
      else $error("threshold write lost");

   a_write_irqen: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_irqen |=> irqen_q == {7'h00, $past(pwdata[0])})
      else $error("interrupt enable write lost");

   a_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && hit_ctrl) |=> $stable(ctrl_q))
      else $error("control changed without a write");

   a_thresh_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && hit_thresh) |=> $stable(thresh_q))
      else $error("threshold changed without a write");

   a_read_status: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_status |=> prdata == {24'h00_0000, 3'b000, $past(synced), 3'b000, $past(flag)})
      else $error("status read wrong");

   a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && !(hit_ctrl || hit_mux || hit_thresh || hit_irqen || hit_status)
      |=> prdata == 32'h0000_0000)
      else $error("reserved offset read not zero");

   a_edge_sets: assert property (@(posedge pclk) disable iff (!presetn)
      edge_hit |=> flag)
      else $error("qualifying edge did not set flag");

   a_rise_sets: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl.edge_select == EDGE_RISE && rise |=> flag)
      else $error("rising edge missed in rise mode");

   a_fall_sets: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl.edge_select == EDGE_FALL && fall |=> flag)
      else $error("falling edge missed in fall mode");

   a_any_sets: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl.edge_select == EDGE_ANY && (rise || fall) |=> flag)
      else $error("edge missed in both-edge mode");

   a_fall_only: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl.edge_select == EDGE_FALL && rise && !flag && !flag_clr |=> !flag)
      else $error("rising edge set flag in fall mode");

   a_flag_source: assert property (@(posedge pclk) disable iff (!presetn)
      !flag && !edge_hit |=> !flag)
      else $error("flag set without an edge");

   a_irq_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
      compare_irq |-> flag)
      else $error("irq without flag");

   a_irq_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      !irqen_q[0] |=> !compare_irq)
      else $error("irq while disabled");

   a_pad_follows: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> pad_out == $past(out_level))
      else $error("pad does not follow output");

   a_event_level: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> compare_event == $past(out_level))
      else $error("event does not follow output");

   a_pad_oe_on: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl.pad_output_enable && running |=> pad_oe)
      else $error("pad not driven while enabled");

   a_halt_standby: assert property (@(posedge pclk) disable iff (!presetn)
      standby_sleep && !ctrl.standby_run |=> !analog_ctrl.enable && !compare_event)
      else $error("comparator ran in standby");

   a_run_standby: assert property (@(posedge pclk) disable iff (!presetn)
      standby_sleep && ctrl.standby_run && ctrl.enable |=> analog_ctrl.enable)
      else $error("comparator halted despite standby run");

   a_enable_off: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl.enable |=> !analog_ctrl.enable)
      else $error("comparator on while disabled");

   a_low_power: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> analog_ctrl.low_power == $past(ctrl.low_power))
      else $error("low power control wrong");

   a_hysteresis: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> analog_ctrl.hysteresis_level == $past(ctrl.hysteresis_level))
      else $error("hysteresis control wrong");

   a_pos_select: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> analog_ctrl.pos_input_select == $past(mux_q[MUX_POS_LSB +: 2]))
      else $error("positive select wrong");

   a_neg_reference: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> analog_ctrl.use_threshold == $past(mux_q[1:0] == NEG_THRESH))
      else $error("reference select wrong");

   a_threshold_out: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> analog_ctrl.threshold_level == $past(thresh_q))
      else $error("threshold level not passed on");

endmodule : cmpc_regs

// ===== cmpc_regs_bench.sv
// Purpose: self-checking bench for the comparator control registers
// Assumes: zero-wait apb slave, byte address is four times the index
// Notes: reads are noted in a queue, a monitor pops and compares them
`timescale 1ns/10ps
module cmpc_regs_bench;
   import cmpc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, f;
   logic standby_sleep, raw_compare, pad_out, pad_oe, compare_event, compare_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lfsr;
   logic [3:0] pstrb;
   logic [1:0] modes [4] = '{EDGE_ANY, EDGE_FALL, EDGE_RISE, 2'h1};
   cmpc_analog_t analog_ctrl;
   logic [31:0] exp_q [$];
   int bad_count, n_tests, cyc;
   cmpc_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .standby_sleep(standby_sleep),
      .raw_compare(raw_compare), .analog_ctrl(analog_ctrl), .pad_out(pad_out),
      .pad_oe(pad_oe), .compare_event(compare_event), .compare_irq(compare_irq));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      n_tests++;
      if (got !== want) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, want);
      end
   endtask : chk
   // request held until pready is seen high, then released
   task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {6'h00, idx, 2'h0};
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [3:0] idx, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      apb(1'b0, idx, 8'h00);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("MISMATCH at %0t: read not expected", $time);
         end else begin
            chk(prdata, exp_q.pop_front());
            chk({31'h0000_0000, pslverr}, 32'h0000_0000);
         end
      end
   end
   // generous ceiling: the sequence needs well under 2000 cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         $display("MISMATCH at %0t: timeout", $time);
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0000_0000; pstrb = 4'hf; standby_sleep = 1'b0; raw_compare = 1'b0;
      lfsr = 32'h0000_d0d6; bad_count = 0; n_tests = 0; cyc = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(IDX_CTRL, 8'h00);
      rd(IDX_MUX, 8'h00);
      rd(IDX_THRESH, 8'hff);
      rd(IDX_IRQEN, 8'h00);
      rd(IDX_STATUS, 8'h00);
      foreach (modes[k]) begin
         apb(1'b1, 4'(2 * k + 1), 8'hff);
         rd(4'(2 * k + 1), 8'h00);
      end
      $display("reset values done");
      repeat (6) begin
         lfsr = nxt(lfsr);
         apb(1'b1, IDX_MUX, lfsr[7:0]);
         rd(IDX_MUX, lfsr[7:0] & MUX_WMASK);
         apb(1'b1, IDX_THRESH, lfsr[15:8]);
         rd(IDX_THRESH, lfsr[15:8]);
         apb(1'b1, IDX_IRQEN, lfsr[23:16]);
         rd(IDX_IRQEN, lfsr[23:16] & IRQEN_WMASK);
         apb(1'b1, IDX_CTRL, {lfsr[31:25], 1'b1});
         rd(IDX_CTRL, {lfsr[31:25], 1'b1});
         chk(analog_ctrl, {1'b1, lfsr[27:25], lfsr[4:3], lfsr[1:0], &lfsr[1:0],
            lfsr[15:8]});
      end
      $display("register access done");
      apb(1'b1, IDX_MUX, 8'h00);
      foreach (modes[k]) begin
         apb(1'b1, IDX_CTRL, {2'b00, modes[k], 4'h1});
         repeat (6) @(posedge pclk);
         apb(1'b1, IDX_STATUS, 8'h01);
         apb(1'b1, IDX_IRQEN, 8'h01);
         raw_compare <= 1'b1;
         repeat (6) @(posedge pclk);
         f = (modes[k] == EDGE_ANY || modes[k] == EDGE_RISE);
         rd(IDX_STATUS, {7'h08, f});
         chk(compare_irq, f);
         chk(compare_event, 1'b1);
         apb(1'b1, IDX_STATUS, 8'h00);
         rd(IDX_STATUS, {7'h08, f});
         apb(1'b1, IDX_STATUS, 8'h01);
         raw_compare <= 1'b0;
         repeat (6) @(posedge pclk);
         f = (modes[k] == EDGE_ANY || modes[k] == EDGE_FALL);
         rd(IDX_STATUS, {7'h00, f});
         chk(compare_irq, f);
         apb(1'b1, IDX_STATUS, 8'h01);
      end
      $display("edge modes done");
      apb(1'b1, IDX_CTRL, 8'h41);
      repeat (4) @(posedge pclk);
      chk({pad_oe, pad_out}, 2'b10);
      raw_compare <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({pad_out, compare_event}, 2'b11);
      apb(1'b1, IDX_MUX, 8'h80);
      repeat (4) @(posedge pclk);
      chk(compare_event, 1'b0);
      apb(1'b1, IDX_MUX, 8'h00);
      standby_sleep <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(compare_event, 1'b0);
      standby_sleep <= 1'b0;
      apb(1'b1, IDX_CTRL, 8'h81);
      repeat (6) @(posedge pclk);
      apb(1'b1, IDX_STATUS, 8'h01);
      // edges seen only while asleep must not reach the flag
      standby_sleep <= 1'b1;
      raw_compare <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(compare_event, 1'b0);
      raw_compare <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(compare_event, 1'b1);
      standby_sleep <= 1'b0;
      repeat (6) @(posedge pclk);
      rd(IDX_STATUS, 8'h10);
      $display("pad and standby done");
      end_of_test();
   end
endmodule : cmpc_regs_bench
